//--- fie_pkg.sv
// constants, types and helpers shared by the file-register execution block
package fie_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned INSTR_W   = 14;
  localparam int unsigned PC_W      = 15;
  localparam int unsigned FADDR_W   = 7;
  localparam int unsigned PAGE_W    = 7;
  localparam int unsigned LIT_W     = 11;
  // instruction field positions
  localparam int unsigned OPC_MSB   = 13;
  localparam int unsigned OPC_LSB   = 8;
  localparam int unsigned BR_LSB    = 11;
  localparam int unsigned D_BIT     = 7;
  localparam int unsigned F_MSB     = 6;
  localparam int unsigned F_LSB     = 0;
  localparam int unsigned LIT_MSB   = 10;
  localparam int unsigned PL_MSB    = 6;
  localparam int unsigned PL_LSB    = 3;
  // opcodes
  localparam logic [5:0] OP_COMPLEMENT = 6'h09;
  localparam logic [5:0] OP_DECREMENT  = 6'h03;
  localparam logic [5:0] OP_DEC_SKIP   = 6'h0b;
  localparam logic [5:0] OP_INCREMENT  = 6'h0a;
  localparam logic [5:0] OP_INC_SKIP   = 6'h0f;
  localparam logic [2:0] OP_BRANCH     = 3'h5;
  // reset values and arithmetic step
  localparam logic [PC_W-1:0]   PC_RST   = 15'h0000;
  localparam logic [DATA_W-1:0] W_RST    = 8'h00;
  localparam logic [DATA_W-1:0] ONE      = 8'h01;
  localparam logic [PC_W-1:0]   PC_STEP  = 15'h0001;

  typedef enum logic {ST_EXEC, ST_NOP} fie_phase_t;

  typedef struct packed {
    fie_phase_t              phase;
    logic                    skip_pend;
    logic [DATA_W-1:0]       w;
    logic                    z;
    logic [PC_W-1:0]         pc;
    logic [FADDR_W-1:0]      faddr;
    logic [DATA_W-1:0]       fwdata;
    logic                    fwe;
    logic                    rdy;
    logic                    disc;
  } fie_state_t;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction
endpackage

//--- fie_alu_if.sv
// carrier between the sequencer and the operation decoder
`timescale 1ns/100ps
interface fie_alu_if;
  import fie_pkg::*;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0]  fdata;
  logic [DATA_W-1:0]  result;
  logic               known;
  logic               to_file;
  logic               upd_z;
  logic               skip_zero;
  logic               branch;
  modport alu (input instr, input fdata, output result, output known, output to_file,
               output upd_z, output skip_zero, output branch);
  modport ctl (output instr, output fdata, input result, input known, input to_file,
               input upd_z, input skip_zero, input branch);
endinterface

//--- fie_alu.sv
// operation decoder and result arithmetic for the file-register group
`timescale 1ns/100ps
module fie_alu (
  fie_alu_if.alu bus
);
  import fie_pkg::*;
  logic [5:0] opc;

  always_comb begin
    opc           = bus.instr[OPC_MSB:OPC_LSB];
    bus.result    = bus.fdata;
    bus.known     = 1'b1;
    bus.upd_z     = 1'b0;
    bus.skip_zero = 1'b0;
    bus.branch    = 1'b0;
    bus.to_file   = bus.instr[D_BIT];                        // [RL2]
    case (opc)
      OP_COMPLEMENT: begin
        bus.result = ~bus.fdata;                            // [RL1]
        bus.upd_z  = 1'b1;
      end
      OP_DECREMENT: begin
        bus.result = bus.fdata - ONE;                       // [RL3] [RL9]
        bus.upd_z  = 1'b1;
      end
      OP_DEC_SKIP: begin
        bus.result    = bus.fdata - ONE;                    // [RL4] [RL9]
        bus.skip_zero = is_zero(bus.result);
      end
      OP_INCREMENT: begin
        bus.result = bus.fdata + ONE;                       // [RL5] [RL9]
        bus.upd_z  = 1'b1;
      end
      OP_INC_SKIP: begin
        // flags deliberately untouched
        bus.result    = bus.fdata + ONE;                    // [RL6] [RL9]
        bus.skip_zero = is_zero(bus.result);
      end
      default: begin
        bus.known  = bus.instr[OPC_MSB:BR_LSB] == OP_BRANCH;
        bus.branch = bus.known;                             // [RL7]
      end
    endcase
  end
endmodule // fie_alu

//--- fie_exec.sv
// execution sequencer for complement, inc/dec, skip-on-zero and literal branch
// Summary of operation
// [RL1] complement writes inverted file value, updates zero
// [RL2] destination bit 0 to work, 1 to file
// [RL3] decrement writes value minus one, updates zero
// [RL4] decrement-skip: zero result discards next, two cycles
// [RL5] increment writes value plus one, updates zero
// [RL6] increment-skip: flags kept, zero result skips next
// [RL7] branch: literal to pc low, latch bits high
// [RL8] branch takes two cycles, flags unchanged
// [RL9] increment and decrement wrap modulo 256
`timescale 1ns/100ps
module fie_exec (
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  input  wire logic                       instr_valid,
  input  wire logic [fie_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [fie_pkg::DATA_W-1:0]  file_rdata,
  input  wire logic [fie_pkg::PAGE_W-1:0]  page_latch,
  output logic                            ready,
  output logic [fie_pkg::FADDR_W-1:0]      file_addr,
  output logic [fie_pkg::DATA_W-1:0]       file_wdata,
  output logic                            file_we,
  output logic [fie_pkg::DATA_W-1:0]       work_reg,
  output logic                            zero_flag,
  output logic [fie_pkg::PC_W-1:0]         prog_counter,
  output logic                            discard_next
);
  import fie_pkg::*;

  fie_alu_if  alu_bus ();
  fie_state_t st_reg;
  fie_state_t st_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       accept;
  logic [PC_W-1:0] branch_target;

  fie_alu u_alu (
    .bus (alu_bus.alu)
  );

  assign alu_bus.instr = instr_word;
  assign alu_bus.fdata = file_rdata;

  // reset released through two flops so every state flop leaves reset on one edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign accept        = instr_valid && st_reg.rdy;
  assign branch_target = {page_latch[PL_MSB:PL_LSB], instr_word[LIT_MSB:0]};

  always_comb begin
    st_next      = st_reg;
    st_next.fwe  = 1'b0;
    st_next.disc = 1'b0;
    case (st_reg.phase)
      ST_EXEC: begin
        if (instr_valid) begin
          st_next.pc    = st_reg.pc + PC_STEP;
          st_next.faddr = instr_word[F_MSB:F_LSB];
          if (alu_bus.branch) begin
            st_next.pc        = branch_target;             // [RL7]
            st_next.phase     = ST_NOP;                    // [RL8]
            st_next.skip_pend = 1'b0;
            st_next.disc      = 1'b1;
          end else if (alu_bus.known) begin
            if (alu_bus.to_file) begin                     // [RL2]
              st_next.fwe    = 1'b1;
              st_next.fwdata = alu_bus.result;
            end else begin
              st_next.w = alu_bus.result;
            end
            if (alu_bus.upd_z) begin
              st_next.z = is_zero(alu_bus.result);         // [RL1] [RL3] [RL5]
            end
            if (alu_bus.skip_zero) begin
              st_next.phase     = ST_NOP;                  // [RL4] [RL6]
              st_next.skip_pend = 1'b1;
              st_next.disc      = 1'b1;
            end
          end
        end
      end
      ST_NOP: begin
        // the discarded word still occupies its address when skipping
        if (st_reg.skip_pend) begin
          st_next.pc = st_reg.pc + PC_STEP;
        end
        st_next.skip_pend = 1'b0;
        st_next.phase     = ST_EXEC;
      end
      default: begin
        st_next.phase = ST_EXEC;
      end
    endcase
    st_next.rdy = st_next.phase == ST_EXEC;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{phase: ST_EXEC, skip_pend: 1'b0, w: W_RST, z: 1'b0, pc: PC_RST,
                  faddr: '0, fwdata: '0, fwe: 1'b0, rdy: 1'b1, disc: 1'b0};
    end else if (!rst_n) begin
      st_reg <= '{phase: ST_EXEC, skip_pend: 1'b0, w: W_RST, z: 1'b0, pc: PC_RST,
                  faddr: '0, fwdata: '0, fwe: 1'b0, rdy: 1'b1, disc: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ready        = st_reg.rdy;
  assign file_addr    = st_reg.faddr;
  assign file_wdata   = st_reg.fwdata;
  assign file_we      = st_reg.fwe;
  assign work_reg     = st_reg.w;
  assign zero_flag    = st_reg.z;
  assign prog_counter = st_reg.pc;
  assign discard_next = st_reg.disc;

  // checks
  logic [DATA_W-1:0] dest_val;
  logic [5:0]        opc;
  assign dest_val = file_we ? file_wdata : work_reg;
  assign opc      = instr_word[OPC_MSB:OPC_LSB];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  comp_value_a: assert property (accept && opc == OP_COMPLEMENT |=> dest_val == ~$past(file_rdata)) // [RL1]
    else $error("complement result wrong");
  dest_select_a: assert property (accept && alu_bus.known && !alu_bus.branch
                                  |=> file_we == $past(instr_word[D_BIT])) // [RL2]
    else $error("destination select wrong");
  dec_value_a: assert property (accept && opc == OP_DECREMENT |=> dest_val == $past(file_rdata) - ONE
                                && zero_flag == is_zero(dest_val)) // [RL3]
    else $error("decrement result or zero wrong");
  dec_skip_a: assert property (accept && opc == OP_DEC_SKIP && file_rdata == ONE
                               |=> (discard_next && !ready) ##1 ready) // [RL4]
    else $error("decrement skip not two cycles");
  inc_zero_a: assert property (accept && opc == OP_INCREMENT
                               |=> zero_flag == is_zero(dest_val) && dest_val == $past(file_rdata) + ONE) // [RL5]
    else $error("increment result or zero wrong");
  inc_skip_flags_a: assert property (accept && opc == OP_INC_SKIP |=> $stable(zero_flag)) // [RL6]
    else $error("increment skip changed flags");
  branch_target_a: assert property (accept && alu_bus.branch |=> prog_counter == $past(branch_target)) // [RL7]
    else $error("branch target wrong");
  branch_cycles_a: assert property (accept && alu_bus.branch
                                    |=> (!ready && $stable(zero_flag)) ##1 (ready && $stable(prog_counter))) // [RL8]
    else $error("branch timing or flags wrong");
  inc_wrap_a: assert property (accept && opc == OP_INCREMENT && file_rdata == 8'hff
                               |=> zero_flag && dest_val == W_RST) // [RL9]
    else $error("increment did not wrap");

  branch_c: cover property (accept && alu_bus.branch ##2 accept);
  dec_skip_c: cover property (accept && opc == OP_DEC_SKIP && alu_bus.skip_zero);
  inc_skip_c: cover property (accept && opc == OP_INC_SKIP && !alu_bus.skip_zero);
  file_write_c: cover property (accept && opc == OP_COMPLEMENT && instr_word[D_BIT]);
endmodule // fie_exec

//--- tb_top.sv
// self-checking bench for the file-register execution block
`timescale 1ns/100ps
module tb_top;
  import fie_pkg::*;
  localparam logic [5:0] OPS [6] = '{OP_COMPLEMENT, OP_DECREMENT, OP_DEC_SKIP, OP_INCREMENT, OP_INC_SKIP, 6'h00};
  localparam logic [DATA_W-1:0] EDGES [3] = '{8'hff, 8'h00, 8'h01};
  logic                ref_clk;
  logic                arst_n;
  logic                instr_valid;
  logic [INSTR_W-1:0]  instr_word;
  logic [DATA_W-1:0]   file_rdata;
  logic [PAGE_W-1:0]   page_latch;
  logic                ready;
  logic [FADDR_W-1:0]  file_addr;
  logic [DATA_W-1:0]   file_wdata;
  logic                file_we;
  logic [DATA_W-1:0]   work_reg;
  logic                zero_flag;
  logic [PC_W-1:0]     prog_counter;
  logic                discard_next;
  int                  errors;
  int                  tests_run;
  int                  seed;
  logic [DATA_W-1:0]   m_w;
  logic [DATA_W-1:0]   m_wd;
  logic [PC_W-1:0]     m_pc;
  logic [FADDR_W-1:0]  m_fa;
  logic                m_z;
  logic                m_rdy;
  logic                m_we;
  logic                m_disc;
  logic                m_skip;

  fie_exec i_dut (.ref_clk, .arst_n, .instr_valid, .instr_word, .file_rdata, .page_latch, .ready, .file_addr,
                  .file_wdata, .file_we, .work_reg, .zero_flag, .prog_counter, .discard_next);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic compare_all();
    chk_bit(ready, m_rdy);
    chk_bit(discard_next, m_disc);
    chk_bit(file_we, m_we);
    chk_val(PC_W'(work_reg), PC_W'(m_w));
    chk_bit(zero_flag, m_z);
    chk_val(prog_counter, m_pc);
    if (m_we) begin
      chk_val(PC_W'(file_wdata), PC_W'(m_wd));
      chk_val(PC_W'(file_addr), PC_W'(m_fa));
    end
  endtask

  // predicts the outputs after the coming rising edge from the inputs now applied
  task automatic model();
    logic [5:0]        op;
    logic [DATA_W-1:0] r;
    m_we = 1'b0;
    m_disc = 1'b0;
    op = instr_word[13:8];
    if (!m_rdy) begin
      m_rdy = 1'b1;
      if (m_skip) m_pc = m_pc + 15'h0001;
    end else if (instr_valid) begin
      m_fa = instr_word[6:0];
      if (instr_word[13:11] == 3'h5) begin
        m_pc = {page_latch[6:3], instr_word[10:0]};
        m_disc = 1'b1;
        m_rdy = 1'b0;
        m_skip = 1'b0;
      end else begin
        m_pc = m_pc + 15'h0001;
        case (op)
          OP_COMPLEMENT: r = ~file_rdata;
          OP_DECREMENT, OP_DEC_SKIP: r = file_rdata - 8'h01;
          OP_INCREMENT, OP_INC_SKIP: r = file_rdata + 8'h01;
          default: r = 8'h00;
        endcase
        if (op inside {OP_COMPLEMENT, OP_DECREMENT, OP_DEC_SKIP, OP_INCREMENT, OP_INC_SKIP}) begin
          if (instr_word[7]) begin
            m_we = 1'b1;
            m_wd = r;
          end else m_w = r;
          if (op inside {OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT}) m_z = (r == 8'h00);
          if (op inside {OP_DEC_SKIP, OP_INC_SKIP} && r == 8'h00) begin
            m_disc = 1'b1;
            m_rdy = 1'b0;
            m_skip = 1'b1;
          end
        end
      end
    end
  endtask

  // reset mid-run too, so a stale skip or branch state cannot survive it
  task automatic do_reset();
    @(negedge ref_clk);
    arst_n = 1'b0;
    instr_valid = 1'b0;
    {m_w, m_wd, m_pc, m_fa, m_z, m_we, m_disc, m_skip} = '0;
    m_rdy = 1'b1;
    repeat (6) @(negedge ref_clk);
    compare_all();
    arst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic run(input int n);
    int sel;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      compare_all();
      sel = $unsigned($random(seed)) % 7;
      instr_valid = ($random(seed) & 7) != 0;
      if (sel == 6) instr_word = {3'h5, 11'($random(seed))};
      else instr_word = {OPS[sel], 8'($random(seed))};
      file_rdata = ($random(seed) & 1) ? EDGES[$unsigned($random(seed)) % 3] : 8'($random(seed));
      page_latch = 7'($random(seed));
      model();
    end
  endtask

  initial begin
    seed = 32'hf9f7d149;
    errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = '0;
    file_rdata = '0;
    page_latch = '0;
    do_reset();
    run(2000);
    do_reset();
    run(1000);
    @(negedge ref_clk);
    compare_all();
    wrap_up();
  end

  // about 3030 cycles expected; double that before giving up
  initial begin
    #(6000 * 50);
    errors++;
    wrap_up();
  end
endmodule // tb_top
